// File: hdl/mcg_encoder.sv
/*
  Manchester / bit-sequential serial encoder with its register file.
  Registers are reached through a byte-wide SFR port (address, write strobe,
  data) as the host CPU provides; reads are combinational from flip-flops.
  Assumes the port pin mux is configured by software outside this block.
*/
`timescale 1ns/10ps
// Behaviour
// - Stopped mode holds pin idle, logic quiet
// - Manchester mode sends Manchester-coded bits
// - Bit-sequential mode holds level per bit
// - Bit count, idle level, bit order selectable
// - Buffer write starts transfer only when enabled
// - Word loaded into 8-bit shift register
// - Control 0 bit 1 selects code
// - Transmit buffer writable, resets to all ones
// - Interrupt pulse when a transfer starts
// - Bit count retained across transfers
// - Three-bit count n sends n+1 bits
// - Short transfers send low-order bits
// - Control 0 byte or bit access, reset 10
// - Prescaler and 5-bit divider make baud
// - Divider k from 4 to 31, halved
// - Busy flag during transfers, clears properly
// - Idle level selectable low or high
module mcg_encoder
  import mcg_pkg::*;
(
  input  wire logic        clk,                // System clock, 25 MHz
  input  wire logic        rst_n,              // Synchronous reset, active low
  input  wire logic [15:0] sfr_addr,           // Register address
  input  wire logic        sfr_wr,             // Write strobe, one cycle
  input  wire logic [7:0]  sfr_wdata,          // Write data
  output logic [7:0]       sfr_rdata,          // Read data for sfr_addr
  output logic             serial_out_pin,     // Encoded serial output
  output logic             transmit_start_irq  // Pulse when a transfer starts
);
  logic [7:0] transmit_buffer;
  logic [2:0] transmit_bit_count;
  mcg_ctl_t   ctl;
  logic [2:0] base_clock_select;
  logic [4:0] baud_divider_k;
  logic       transmit_in_progress;
  logic       pending;
  logic [7:0] shift;
  logic [2:0] bits_left;
  logic       cur_bit;
  mcg_state_t state;
  logic       half_tick;
  logic       buf_wr;
  logic       ctl0_wr;
  logic       load_now;
  logic       last_half;
  logic [7:0] ctl0_byte;
  logic       take_wr;
  logic [7:0] tx_word;

  // ==========================================================================
  // Helpers
  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    return sfr_wr && (a == r);
  endfunction : hit

  // Align word so the first bit to send sits at the shift-out end
  function automatic logic [7:0] align(input logic [7:0] d, input logic [2:0] n,
                                       input logic lsb);
    logic [7:0] r;
    r = d;
    if (!lsb) begin
      r = d << (3'h7 - n);
    end
    return r;
  endfunction : align

  assign buf_wr  = hit(sfr_addr, ADDR_TX_BUF);
  assign ctl0_wr = hit(sfr_addr, ADDR_CTL0);
  assign last_half = half_tick && (state == MCG_SECOND);
  // A write on the final tick with nothing queued is sent at once, since
  // the buffer flop only takes the new word on that same edge
  assign take_wr = buf_wr && !pending;
  assign tx_word = take_wr ? sfr_wdata : transmit_buffer;

  // ==========================================================================
  // Registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl <= '{enable: RST_CTL0[CTL0_EN_BIT], lsb_first: RST_CTL0[CTL0_DIR_BIT],
               bit_seq: RST_CTL0[CTL0_OSL_BIT], idle_high: RST_CTL0[CTL0_OLV_BIT]};
    end else if (ctl0_wr) begin
      ctl.enable    <= sfr_wdata[CTL0_EN_BIT];
      ctl.lsb_first <= sfr_wdata[CTL0_DIR_BIT];
      ctl.bit_seq   <= sfr_wdata[CTL0_OSL_BIT];
      ctl.idle_high <= sfr_wdata[CTL0_OLV_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      transmit_buffer <= RST_TX_BUF;
    end else if (buf_wr) begin
      transmit_buffer <= sfr_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      transmit_bit_count <= RST_BIT_CNT;
    end else if (hit(sfr_addr, ADDR_BIT_CNT)) begin
      transmit_bit_count <= sfr_wdata[2:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      base_clock_select <= RST_CTL1;
      baud_divider_k    <= RST_CTL2;
    end else begin
      if (hit(sfr_addr, ADDR_CTL1) && sfr_wdata[2:0] <= CKS_MAX) begin
        base_clock_select <= sfr_wdata[2:0];
      end
      if (hit(sfr_addr, ADDR_CTL2)) begin
        baud_divider_k <= sfr_wdata[4:0];
      end
    end
  end

  // ==========================================================================
  // Baud generator
  mcg_baud u_baud (
    .clk       (clk),
    .rst_n     (rst_n),
    .run       (ctl.enable),
    .cks       (base_clock_select),
    .brs       (baud_divider_k),
    .half_tick (half_tick)
  );

  // ==========================================================================
  // Transfer sequencer. A queued word starts on the tick ending the last bit,
  // so continuous transfers leave no idle gap.
  assign load_now = (state == MCG_IDLE && pending) ||
                    (last_half && bits_left == 3'h0 && (pending || buf_wr));

  always_ff @(posedge clk) begin
    if (!rst_n || !ctl.enable) begin
      pending <= 1'b0;
    end else if (buf_wr && !(load_now && take_wr)) begin
      pending <= 1'b1;
    end else if (load_now) begin
      pending <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !ctl.enable) begin
      state     <= MCG_IDLE;
      shift     <= '0;
      bits_left <= '0;
      cur_bit   <= 1'b0;
    end else if (load_now) begin
      // Bit count is latched here, so a later rewrite only affects next word
      shift     <= align(tx_word, transmit_bit_count, ctl.lsb_first);
      bits_left <= transmit_bit_count;
      state     <= MCG_FIRST;
      cur_bit   <= ctl.lsb_first ? tx_word[0] : tx_word[transmit_bit_count];
    end else if (half_tick) begin
      case (state)
        MCG_FIRST: begin
          state <= MCG_SECOND;
        end
        MCG_SECOND: begin
          if (bits_left == 3'h0) begin
            state <= MCG_IDLE;
          end else begin
            bits_left <= bits_left - 1'b1;
            state     <= MCG_FIRST;
            shift     <= ctl.lsb_first ? (shift >> 1) : (shift << 1);
            cur_bit   <= ctl.lsb_first ? shift[1] : shift[6];
          end
        end
        default: begin
          state <= MCG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !ctl.enable) begin
      transmit_in_progress <= 1'b0;
    end else if (load_now) begin
      transmit_in_progress <= 1'b1;
    end else if (last_half && bits_left == 3'h0) begin
      transmit_in_progress <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      transmit_start_irq <= 1'b0;
    end else begin
      transmit_start_irq <= load_now && ctl.enable;
    end
  end

  // ==========================================================================
  // Pin. Manchester: bit value in first half, inverted in second half.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      serial_out_pin <= RST_CTL0[CTL0_OLV_BIT];
    end else if (state == MCG_IDLE || !ctl.enable) begin
      serial_out_pin <= ctl.idle_high;
    end else if (ctl.bit_seq) begin
      serial_out_pin <= cur_bit;
    end else begin
      serial_out_pin <= (state == MCG_SECOND) ? !cur_bit : cur_bit;
    end
  end

  // ==========================================================================
  // Read mux
  assign ctl0_byte = {ctl.enable, 2'b00, ctl.lsb_first, 2'b00, ctl.bit_seq, ctl.idle_high};

  always_comb begin
    case (sfr_addr)
      ADDR_TX_BUF:  sfr_rdata = transmit_buffer;
      ADDR_BIT_CNT: sfr_rdata = {5'h00, transmit_bit_count};
      ADDR_CTL0:    sfr_rdata = ctl0_byte;
      ADDR_CTL1:    sfr_rdata = {5'h00, base_clock_select};
      ADDR_CTL2:    sfr_rdata = {3'h0, baud_divider_k};
      ADDR_STATUS:  sfr_rdata = {transmit_in_progress, 7'h00};
      default:      sfr_rdata = 8'h00;
    endcase
  end

  // ==========================================================================
  // Checks
  idle_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!ctl.enable && !$past(ctl.enable)) |-> serial_out_pin == ctl.idle_high)
    else $error("pin not at idle level while stopped");
  start_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    (buf_wr && ctl.enable && state == MCG_IDLE && !pending) |=> ##1 transmit_start_irq)
    else $error("no start interrupt after write");
  no_start_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    !ctl.enable |=> !transmit_start_irq) else $error("start while disabled");
  busy_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state != MCG_IDLE) |-> transmit_in_progress) else $error("busy flag low");
  // The enable flop falls on the write edge, the busy flop one edge later
  busy_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(ctl.enable) |=> !transmit_in_progress) else $error("busy not cleared");
  manch_mid_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ctl.enable && !ctl.bit_seq && $past(state) == MCG_FIRST && state == MCG_SECOND)
    |=> serial_out_pin == !$past(serial_out_pin)) else $error("no mid-bit edge");
  nrz_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ctl.enable && ctl.bit_seq && $past(state) == MCG_FIRST && state == MCG_SECOND)
    |=> $stable(serial_out_pin)) else $error("level changed mid-bit");
  cnt_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    !hit(sfr_addr, ADDR_BIT_CNT) |=> $stable(transmit_bit_count))
    else $error("bit count changed");
  start_cov: cover property (@(posedge clk) transmit_start_irq);
  chain_cov: cover property (@(posedge clk) last_half && bits_left == 3'h0 && pending);
  nrz_cov:   cover property (@(posedge clk) ctl.bit_seq && state == MCG_SECOND);
endmodule : mcg_encoder

// File: common/mcg_pkg.sv
/*
  Package for the line-code generator: register addresses, reset values,
  field positions, baud timing limits and the encoder state type.
  Assumes an 8-bit special-function-register access port in the host CPU.
*/
package mcg_pkg;
  // ==========================================================================
  // Register addresses (8-bit SFR space)
  localparam logic [15:0] ADDR_STATUS   = 16'hff47;
  localparam logic [15:0] ADDR_CTL2     = 16'hff4a;
  localparam logic [15:0] ADDR_BIT_CNT  = 16'hff4b;
  localparam logic [15:0] ADDR_CTL0     = 16'hff4c;
  localparam logic [15:0] ADDR_CTL1     = 16'hff4d;
  localparam logic [15:0] ADDR_TX_BUF   = 16'hff4e;
  // ==========================================================================
  // Reset values
  localparam logic [7:0]  RST_TX_BUF    = 8'hff;
  localparam logic [2:0]  RST_BIT_CNT   = 3'h7;
  localparam logic [7:0]  RST_CTL0      = 8'h10;
  localparam logic [2:0]  RST_CTL1      = 3'h0;
  localparam logic [4:0]  RST_CTL2      = 5'h1f;
  // ==========================================================================
  // Field positions in control register 0 and the status register
  localparam int          CTL0_EN_BIT   = 7;
  localparam int          CTL0_DIR_BIT  = 4;
  localparam int          CTL0_OSL_BIT  = 1;
  localparam int          CTL0_OLV_BIT  = 0;
  localparam int          STAT_TIP_BIT  = 7;
  // ==========================================================================
  // Baud generator limits
  localparam logic [4:0]  K_MIN         = 5'h04;
  localparam int          PRESC_W       = 6;
  localparam logic [2:0]  CKS_MAX       = 3'h5;

  typedef struct packed {
    logic enable;
    logic lsb_first;
    logic bit_seq;
    logic idle_high;
  } mcg_ctl_t;

  typedef enum logic [1:0] {
    MCG_IDLE,
    MCG_FIRST,
    MCG_SECOND
  } mcg_state_t;
endpackage : mcg_pkg

// File: hdl/mcg_baud.sv
/*
  Baud generator: prescaler picks the base clock, 5-bit counter divides it
  by k (k below four acts as four), and a final divide by two gives the bit
  rate. Emits one-cycle half-bit enables for the encoder.
  Assumes one clock and that settings change only while stopped.
*/
`timescale 1ns/10ps
module mcg_baud
  import mcg_pkg::*;
(
  input  wire logic       clk,       // System clock
  input  wire logic       rst_n,     // Synchronous reset, active low
  input  wire logic       run,       // Divider runs only while enabled
  input  wire logic [2:0] cks,       // Base clock select
  input  wire logic [4:0] brs,       // Divider value k
  output logic            half_tick  // One pulse per half bit period
);
  logic [PRESC_W-1:0] presc;
  logic [4:0]         cnt;
  logic               base_tick;
  logic [4:0]         k_eff;

  // ==========================================================================
  // Prescaler: base tick every 2^cks cycles
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      presc <= '0;
    end else begin
      presc <= presc + 1'b1;
    end
  end

  always_comb begin
    if (cks == '0) begin
      base_tick = 1'b1;
    end else begin
      base_tick = (presc & ((PRESC_W'(1) << cks) - 1'b1)) == '0;
    end
  end

  assign k_eff = (brs < K_MIN) ? K_MIN : brs;

  // ==========================================================================
  // Divide by k; each wrap is one half bit, so two wraps make one bit
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      cnt <= '0;
    end else if (base_tick) begin
      cnt <= (cnt == k_eff - 1'b1) ? 5'h00 : cnt + 1'b1;
    end
  end

  assign half_tick = run && base_tick && (cnt == k_eff - 1'b1);

  // Largest base clock select needs a 5-bit prescale mask
  if (PRESC_W < 6) begin : g_presc_chk
    $error("prescaler too narrow");
  end

  stop_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    !run |-> !half_tick) else $error("baud tick while stopped");
  k_floor_a: assert property (@(posedge clk) disable iff (!rst_n)
    (half_tick && cks == 3'h0 && brs < K_MIN && $stable(run)) |=> !half_tick [*3])
    else $error("divider below four");
endmodule : mcg_baud

// File: verif/mcg_rx_model.sv
/*
  Remote receiver model: oversamples the encoded line every cycle and
  rebuilds half-bit slots from run lengths, then decodes one word.
  Assumes frame_start marks the cycle before the first half bit (the pin
  is registered one edge after the start pulse), and that every half bit
  except the first lasts half_len cycles.
*/
`timescale 1ns/10ps
module mcg_rx_model (
  input  wire logic       clk,         // System clock
  input  wire logic       line_in,     // Encoded line
  input  wire logic       frame_start, // Cycle before the first half bit of a word
  input  wire logic [7:0] half_len,    // Cycles per half bit
  input  wire logic [2:0] count,       // Bits in the word minus one
  input  wire logic       bit_seq,     // Level per bit, no mid transition
  output logic      [7:0] rx_bits,     // Bit i is the i-th bit received
  output logic            rx_ok,       // Coding held in every bit
  output logic            rx_valid     // High for one cycle per word
);
  logic slots[$];
  logic cur;
  logic act = 1'b0;
  logic arm = 1'b0;
  logic first;
  logic sq;
  int   len;
  int   h;
  int   n;

  // ==========================================================================
  // Slot rebuild
  // The baud phase is free running, so the first half may be short: round up
  function automatic int part();
    return first ? (len + h - 1) / h : len / h;
  endfunction : part

  initial rx_valid = 1'b0;

  always @(negedge clk) begin
    rx_valid = 1'b0;
    if (arm) begin
      slots.delete();
      act = 1'b1;
      first = 1'b1;
      cur = line_in;
      len = 1;
      h = int'(half_len);
      n = int'(count) + 1;
      sq = bit_seq;
    end else if (act) begin
      if (line_in === cur) begin
        len++;
      end else begin
        repeat (part()) slots.push_back(cur);
        first = 1'b0;
        cur = line_in;
        len = 1;
      end
    end
    // A final half equal to the idle level merges with it, so stop by count
    if (act && slots.size() + part() >= 2 * n) begin
      while (slots.size() < 2 * n) slots.push_back(cur);
      rx_bits = 8'h00;
      rx_ok = 1'b1;
      for (int i = 0; i < n; i++) begin
        rx_bits[i] = slots[2*i];
        if ((slots[2*i+1] === slots[2*i]) !== sq) rx_ok = 1'b0;
      end
      act = 1'b0;
      rx_valid = 1'b1;
    end
    // Latched last so a chained word's pulse cannot cut the running decode
    arm = (frame_start === 1'b1);
  end
endmodule : mcg_rx_model

// File: verif/test_manchester_code_generator.sv
/*
  Self-checking bench for the line-code encoder: register resets, stopped
  writes, all code/order/idle modes, chained words, count retention, abort.
  Assumes the receiver model decodes the pin; expected words sit in a queue.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module test_manchester_code_generator;
  import mcg_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sfr_wr = 1'b0;
  logic [15:0] sfr_addr = 16'h0000;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [7:0]  sfr_rdata;
  logic        serial_out_pin;
  logic        transmit_start_irq;
  logic [7:0]  rx_bits;
  logic        rx_ok;
  logic        rx_valid;
  logic [7:0]  half = 8'h04;
  logic [2:0]  cnt = 3'h7;
  logic        seq = 1'b0;
  logic        dir_l = 1'b0;
  logic        ignore_rx = 1'b0;
  logic [7:0]  e_w;
  logic [7:0]  exp_q[$];
  logic [15:0] reg_a [7] = '{ADDR_TX_BUF, ADDR_BIT_CNT, ADDR_CTL0, ADDR_CTL1, ADDR_CTL2,
                             ADDR_STATUS, 16'hff40};
  logic [7:0]  reg_v [7] = '{8'hff, 8'h07, 8'h10, 8'h00, 8'h1f, 8'h00, 8'h00};
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          irq_seen = 0;
  int          irq_exp = 0;

  mcg_encoder dut_u (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .serial_out_pin(serial_out_pin),
    .transmit_start_irq(transmit_start_irq));
  mcg_rx_model rx_u (.clk(clk), .line_in(serial_out_pin), .frame_start(transmit_start_irq),
    .half_len(half), .count(cnt), .bit_seq(seq), .rx_bits(rx_bits), .rx_ok(rx_ok),
    .rx_valid(rx_valid));

  initial forever #20 clk = ~clk;
  always @(negedge clk) if (transmit_start_irq === 1'b1) irq_seen++;

  // ==========================================================================
  // Result checker
  always @(posedge clk) begin
    if (rx_valid === 1'b1 && !ignore_rx) begin
      if (exp_q.size() == 0) begin
        `CHK("rx_extra", 1'b0, 1'b1)
      end else begin
        e_w = exp_q.pop_front();
        `CHK("rx_bits", e_w, rx_bits)
        `CHK("rx_code", 1'b1, rx_ok)
      end
    end
  end

  // ==========================================================================
  // Bus and sequence tasks
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk);
    #1 sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 sfr_addr = a;
    #5 d = sfr_rdata;
  endtask : rd

  function automatic logic [7:0] expw(input logic [7:0] d, input logic [2:0] c,
                                      input logic lsb);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i <= int'(c); i++) r[i] = lsb ? d[i] : d[int'(c) - i];
    return r;
  endfunction : expw

  task automatic setup(input logic lsb, input logic osl, input logic olv,
                       input logic [2:0] cks, input logic [4:0] k, input logic [2:0] c);
    wr(ADDR_CTL0, {3'b000, lsb, 2'b00, osl, olv});
    wr(ADDR_CTL1, {5'h00, cks});
    wr(ADDR_CTL2, {3'h0, k});
    wr(ADDR_BIT_CNT, {5'h00, c});
    wr(ADDR_CTL0, {3'b100, lsb, 2'b00, osl, olv});
    half = 8'((32'd1 << cks) * ((k < K_MIN) ? int'(K_MIN) : int'(k)));
    cnt = c;
    seq = osl;
    dir_l = lsb;
  endtask : setup

  task automatic send(input logic [7:0] d);
    wr(ADDR_TX_BUF, d);
    exp_q.push_back(expw(d, cnt, dir_l));
    irq_exp++;
  endtask : send

  task automatic wait_irq();
    for (int i = 0; i < 300 && transmit_start_irq !== 1'b1; i++) @(negedge clk);
    `CHK("start_irq", 1'b1, transmit_start_irq)
  endtask : wait_irq

  task automatic wait_idle(input logic olv);
    logic [7:0] s;
    s = 8'h80;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 5000 && s[7] !== 1'b0; i++) rd(ADDR_STATUS, s);
    repeat (2) @(posedge clk);
    `CHK("busy_end", 8'h00, s)
    `CHK("idle_pin", olv, serial_out_pin)
  endtask : wait_idle

  task automatic end_sim();
    if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // ==========================================================================
  // Main sequence
  initial begin
    logic [7:0] v;
    int         seed_set;
    seed_set = $urandom(32'h029c);
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd(reg_a[i], v);
      `CHK("reset_val", reg_v[i], v)
    end
    `CHK("reset_pin", 1'b0, serial_out_pin)
    wr(ADDR_BIT_CNT, 8'hfd);
    rd(ADDR_BIT_CNT, v);
    `CHK("cnt_mask", 8'h05, v)
    wr(ADDR_TX_BUF, 8'h5a);
    repeat (30) @(posedge clk);
    rd(ADDR_TX_BUF, v);
    `CHK("buf_wr", 8'h5a, v)
    `CHK("stopped_irq", 0, irq_seen)
    // Every code, order and idle level; random data, counts and rates
    for (int i = 0; i < 16; i++) begin
      setup(i[0], i[1], i[2], 3'($urandom % 3), (i == 0) ? 5'h02 : 5'($urandom),
            (i == 2) ? 3'h7 : 3'($urandom));
      send(8'($urandom));
      wait_idle(i[2]);
    end
    // Chained words, count changed only after the start pulse
    setup(1'b1, 1'b0, 1'b1, 3'h0, 5'h05, 3'h2);
    send(8'hc6);
    wait_irq();
    wr(ADDR_BIT_CNT, 8'h04);
    cnt = 3'h4;
    send(8'h3b);
    rd(ADDR_STATUS, v);
    `CHK("busy_chain", 8'h80, v)
    wait_idle(1'b1);
    send(8'h96);
    wait_idle(1'b1);
    // Abort mid-word; the receiver's leftover decode is ignored
    setup(1'b0, 1'b0, 1'b1, 3'h1, 5'h1f, 3'h7);
    ignore_rx = 1'b1;
    wr(ADDR_TX_BUF, 8'ha5);
    irq_exp++;
    wait_irq();
    repeat (40) @(posedge clk);
    wr(ADDR_CTL0, 8'h01);
    rd(ADDR_STATUS, v);
    `CHK("abort_busy", 8'h00, v)
    `CHK("abort_pin", 1'b1, serial_out_pin)
    repeat (1100) @(posedge clk);
    ignore_rx = 1'b0;
    `CHK("irq_count", irq_exp, irq_seen)
    `CHK("rx_left", 0, exp_q.size())
    end_sim();
  end

  initial begin
    #(80_000 * 40);
    n_mismatch++;
    end_sim();
  end
endmodule : test_manchester_code_generator
